// ===== rtl/rsc_regs.vh
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// Reset source register bit positions
`define RSC_BIT_PIN        0
`define RSC_BIT_POR        1
`define RSC_BIT_CLK_LOSS   2
`define RSC_BIT_WDT        3
`define RSC_BIT_CMP        5
`define RSC_BIT_CNV        6

// Reset values
`define RSC_FLAGS_RESET    8'h02
`define RSC_PORT_LATCH_RST 8'hff
`define RSC_RESET_VECTOR   16'h0000
`define RSC_WDT_INTERVAL   3'h7
`define RSC_OSC_2MHZ       2'h0

// Timing
`define RSC_CLK_HZ         10000000
`define RSC_POR_TIMEOUT_MS 100
`define RSC_POR_CYCLES     (`RSC_CLK_HZ / 1000 * `RSC_POR_TIMEOUT_MS)
`define RSC_CLK_LOSS_US    100
`define RSC_CLK_LOSS_CYCLES (`RSC_CLK_HZ / 1000000 * `RSC_CLK_LOSS_US)
`define RSC_PIN_HOLD_CYCLES 12

`endif

// ===== rtl/rsc_clk_loss.v
`timescale 1ns/1ns
`default_nettype none
`include "rsc_regs.vh"

module rsc_clk_loss
#(
    parameter CNT_W   = 11,
    parameter TIMEOUT = `RSC_CLK_LOSS_CYCLES
)
(
    input  wire clk,
    input  wire rst,
    input  wire enable,
    input  wire core_clk_toggle,
    output reg  loss
);

    localparam [CNT_W-1:0] LIMIT = TIMEOUT[CNT_W-1:0];

    reg             sync1_q;
    reg             sync2_q;
    reg             prev_q;
    reg [CNT_W-1:0] cnt_q;

    wire activity;

    assign activity = sync2_q ^ prev_q;

    // Retriggerable one-shot on core clock activity
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            cnt_q   <= {CNT_W{1'b0}};
            loss    <= 1'b0;
        end
        else
        begin
            sync1_q <= core_clk_toggle;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            if (!enable || activity) // [R13] [R15]
            begin
                cnt_q <= {CNT_W{1'b0}};
                loss  <= 1'b0;
            end
            else if (cnt_q >= LIMIT)
            begin
                loss <= 1'b1; // [R13]
            end
            else
            begin
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule
`default_nettype wire

// ===== rtl/rsc_reset_ctrl.v
// Contract
// [R1] In reset: halt core, force ports, load defaults; restart at address 0x0000.
// [R2] Reset leaves data memory intact; only stack pointer reinitialised.
// [R3] Every reset sets port latches to 0xFF with pull-ups on.
// [R4] Supply or software power-on reset drives reset pin low for 100 ms.
// [R5] After reset: internal oscillator at 2 MHz, watchdog on at longest interval.
// [R6] Seven causes enter reset: supply, pin, convert start, software, comparator, clock loss, watchdog.
// [R7] Power-on reset sets power-on flag at bit 1.
// [R8] Any other reset source clears the power-on flag.
// [R9] Software writing 1 to power-on flag runs a full power-on reset.
// [R10] Supply below threshold drives pin low; release as power-on reset.
// [R11] Low reset pin enters reset; hold at least 12 cycles after release.
// [R12] Leaving pin reset sets pin reset flag at bit 0.
// [R13] Enabled clock-loss detector resets after 100 us without core clock.
// [R14] Clock-loss flag at bit 2 reads 1 only after that reset; pin untouched.
// [R15] Clock-loss detector active only while its enable is set.
// [R16] Writing 1 to bit 5 arms comparator reset: plus below minus resets.
// [R17] Software enables comparator 20 us before arming it.
// [R18] Bit 5 reads 1 only after comparator reset; pin untouched.
// [R19] Comparator reset path works without the system clock.
// [R20] Writing 1 to bit 6 makes convert start an active-low level reset.
// [R21] Software sets up pin routing before arming convert start reset.
// [R22] Bit 6 reads 1 only after convert start reset; pin untouched.
// [R23] Watchdog overflow resets without driving the reset pin.
// [R24] Causes merge into one reset, released synchronously, clockless paths excepted.
`timescale 1ns/1ns
`default_nettype none
`include "rsc_regs.vh"

module rsc_reset_ctrl
#(
    parameter POR_CYCLES  = `RSC_POR_CYCLES,
    parameter POR_CNT_W   = 20,
    parameter LOSS_CYCLES = `RSC_CLK_LOSS_CYCLES,
    parameter LOSS_CNT_W  = 11
)
(
    input  wire        CLK_SYS,
    input  wire        SYS_RST,
    input  wire        SUPPLY_LOW,
    input  wire        RESET_PIN_N_IN,
    output wire        RESET_PIN_N_OUT,
    output wire        RESET_PIN_N_OE,
    input  wire        CONVERT_START_SIGNAL,
    input  wire        COMPARATOR_PLUS_ABOVE_MINUS,
    input  wire        WATCHDOG_OVERFLOW,
    input  wire        CLOCK_LOSS_ENABLE,
    input  wire        CORE_CLK_TOGGLE,
    input  wire        RSRC_WR_EN,
    input  wire [7:0]  RSRC_WR_DATA,
    output reg  [7:0]  RESET_SOURCE_REG,
    output wire        CORE_RST,
    output wire        RAM_WRITE_BLOCK,
    output reg  [15:0] RESET_VECTOR,
    output reg  [7:0]  PORT_LATCH_VALUE,
    output reg         PULLUP_ENABLE,
    output reg         CLK_SRC_INTERNAL,
    output reg  [1:0]  OSC_FREQ_SEL,
    output reg         WATCHDOG_ENABLE,
    output reg  [2:0]  WATCHDOG_INTERVAL
);

    localparam [2:0] ST_RUN      = 3'd0;
    localparam [2:0] ST_POR_HOLD = 3'd1;
    localparam [2:0] ST_PIN_HOLD = 3'd2;
    localparam [2:0] ST_SRC_HOLD = 3'd3;
    localparam [2:0] ST_RELEASE  = 3'd4;

    localparam integer         PIN_HOLD  = `RSC_PIN_HOLD_CYCLES;
    localparam [POR_CNT_W-1:0] POR_LIMIT = POR_CYCLES[POR_CNT_W-1:0];
    localparam [POR_CNT_W-1:0] PIN_LIMIT = PIN_HOLD[POR_CNT_W-1:0];

    localparam [2:0] CA_POR  = 3'd0;
    localparam [2:0] CA_PIN  = 3'd1;
    localparam [2:0] CA_LOSS = 3'd2;
    localparam [2:0] CA_CMP  = 3'd3;
    localparam [2:0] CA_CNV  = 3'd4;
    localparam [2:0] CA_WDT  = 3'd5;

    reg [2:0]           state_q;
    reg [2:0]           state_d;
    reg [POR_CNT_W-1:0] cnt_q;
    reg [POR_CNT_W-1:0] cnt_d;
    reg [2:0]           cause_q;
    reg [2:0]           cause_d;
    reg                 sw_por_q;
    reg                 cmp_en_q;
    reg                 cnv_en_q;
    reg [7:0]           flags_q;
    reg                 rst_hold_q;

    wire clk_loss;
    wire drive_pin;
    wire pin_low;
    wire por_src;
    wire cmp_src;
    wire cnv_src;
    wire any_src;

    // Flag register image for a given cause
    function [7:0] flags_for;
        input [2:0] cause;
        begin
            flags_for = 8'h00;
            case (cause)
                CA_POR:  flags_for[`RSC_BIT_POR]      = 1'b1; // [R7]
                CA_PIN:  flags_for[`RSC_BIT_PIN]      = 1'b1; // [R12]
                CA_LOSS: flags_for[`RSC_BIT_CLK_LOSS] = 1'b1; // [R14]
                CA_CMP:  flags_for[`RSC_BIT_CMP]      = 1'b1; // [R18]
                CA_CNV:  flags_for[`RSC_BIT_CNV]      = 1'b1; // [R22]
                CA_WDT:  flags_for[`RSC_BIT_WDT]      = 1'b1;
                default: flags_for = 8'h00;
            endcase
        end
    endfunction

    rsc_clk_loss
    #(
        .CNT_W   (LOSS_CNT_W),
        .TIMEOUT (LOSS_CYCLES)
    )
    u_clk_loss
    (
        .clk             (CLK_SYS),
        .rst             (SYS_RST),
        .enable          (CLOCK_LOSS_ENABLE),
        .core_clk_toggle (CORE_CLK_TOGGLE),
        .loss            (clk_loss)
    );

    // Pin driven low only for supply or software power-on reset
    assign drive_pin       = (state_q == ST_POR_HOLD); // [R4] [R10]
    assign RESET_PIN_N_OUT = 1'b0;
    assign RESET_PIN_N_OE  = drive_pin;

    // Own drive is ignored when sampling the pin
    assign pin_low = !RESET_PIN_N_IN && !drive_pin; // [R11]
    assign por_src = SUPPLY_LOW || sw_por_q; // [R9] [R10]
    assign cmp_src = cmp_en_q && !COMPARATOR_PLUS_ABOVE_MINUS; // [R16]
    assign cnv_src = cnv_en_q && !CONVERT_START_SIGNAL; // [R20]
    assign any_src = por_src || pin_low || clk_loss || cmp_src
                     || cnv_src || WATCHDOG_OVERFLOW; // [R6] [R23]

    // Comparator term is combinational so it acts with no clock
    assign CORE_RST = SYS_RST || rst_hold_q || cmp_src; // [R19] [R24] [R1]
    // Writes blocked so memory keeps its contents
    assign RAM_WRITE_BLOCK = CORE_RST; // [R2]

    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        cause_d = cause_q;
        case (state_q)
            ST_RUN:
            begin
                cnt_d = {POR_CNT_W{1'b0}};
                if (por_src)
                begin
                    state_d = ST_POR_HOLD;
                    cause_d = CA_POR;
                end
                else if (pin_low)
                begin
                    state_d = ST_PIN_HOLD;
                    cause_d = CA_PIN;
                end
                else if (clk_loss)
                begin
                    state_d = ST_SRC_HOLD;
                    cause_d = CA_LOSS; // [R13]
                end
                else if (cmp_src)
                begin
                    state_d = ST_SRC_HOLD;
                    cause_d = CA_CMP;
                end
                else if (cnv_src)
                begin
                    state_d = ST_SRC_HOLD;
                    cause_d = CA_CNV;
                end
                else if (WATCHDOG_OVERFLOW)
                begin
                    state_d = ST_SRC_HOLD;
                    cause_d = CA_WDT; // [R23]
                end
            end
            ST_POR_HOLD:
            begin
                // Timeout restarts while supply stays low
                if (SUPPLY_LOW)
                begin
                    cnt_d = {POR_CNT_W{1'b0}};
                end
                else if (cnt_q >= POR_LIMIT - 1'b1)
                begin
                    state_d = ST_RELEASE; // [R4]
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_PIN_HOLD:
            begin
                if (por_src)
                begin
                    state_d = ST_POR_HOLD;
                    cause_d = CA_POR;
                    cnt_d   = {POR_CNT_W{1'b0}};
                end
                else if (pin_low)
                begin
                    cnt_d = {POR_CNT_W{1'b0}};
                end
                else if (cnt_q >= PIN_LIMIT - 1'b1)
                begin
                    state_d = ST_RELEASE; // [R11]
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_SRC_HOLD:
            begin
                if (por_src)
                begin
                    state_d = ST_POR_HOLD;
                    cause_d = CA_POR;
                    cnt_d   = {POR_CNT_W{1'b0}};
                end
                else if (pin_low)
                begin
                    state_d = ST_PIN_HOLD;
                    cause_d = CA_PIN;
                    cnt_d   = {POR_CNT_W{1'b0}};
                end
                else if (!(clk_loss || cmp_src || cnv_src || WATCHDOG_OVERFLOW))
                begin
                    state_d = ST_RELEASE; // [R24]
                end
            end
            ST_RELEASE:
            begin
                if (any_src)
                begin
                    state_d = ST_RUN;
                end
                else
                begin
                    state_d = ST_RUN;
                end
            end
            default:
            begin
                state_d = ST_POR_HOLD;
                cause_d = CA_POR;
                cnt_d   = {POR_CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_q    <= ST_POR_HOLD;
            cnt_q      <= {POR_CNT_W{1'b0}};
            cause_q    <= CA_POR;
            rst_hold_q <= 1'b1;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            cause_q    <= cause_d;
            // Release is registered, one edge after the hold ends
            rst_hold_q <= (state_d != ST_RUN); // [R24]
        end
    end

    // Software requests and source enables
    always @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            sw_por_q <= 1'b0;
            cmp_en_q <= 1'b0;
            cnv_en_q <= 1'b0;
        end
        else if (state_q == ST_RELEASE)
        begin
            sw_por_q <= 1'b0;
            cmp_en_q <= 1'b0;
            cnv_en_q <= 1'b0;
        end
        else if (state_q == ST_RUN && RSRC_WR_EN)
        begin
            sw_por_q <= RSRC_WR_DATA[`RSC_BIT_POR]; // [R9]
            cmp_en_q <= RSRC_WR_DATA[`RSC_BIT_CMP]; // [R16]
            cnv_en_q <= RSRC_WR_DATA[`RSC_BIT_CNV]; // [R20]
        end
        else if (state_q == ST_POR_HOLD)
        begin
            sw_por_q <= 1'b0;
        end
    end

    // Flags take the cause at release; other bits read zero
    always @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            flags_q          <= `RSC_FLAGS_RESET;
            RESET_SOURCE_REG <= `RSC_FLAGS_RESET;
        end
        else
        begin
            // Flags visible on the release edge, one edge after the hold ends
            if (state_q == ST_RELEASE)
            begin
                flags_q          <= flags_for(cause_q); // [R7] [R8]
                RESET_SOURCE_REG <= flags_for(cause_q); // [R12]
            end
            else
            begin
                RESET_SOURCE_REG <= flags_q;
            end
        end
    end

    // Defaults presented to the core while it is held
    always @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RESET_VECTOR      <= `RSC_RESET_VECTOR;
            PORT_LATCH_VALUE  <= `RSC_PORT_LATCH_RST;
            PULLUP_ENABLE     <= 1'b1;
            CLK_SRC_INTERNAL  <= 1'b1;
            OSC_FREQ_SEL      <= `RSC_OSC_2MHZ;
            WATCHDOG_ENABLE   <= 1'b1;
            WATCHDOG_INTERVAL <= `RSC_WDT_INTERVAL;
        end
        else if (rst_hold_q)
        begin
            RESET_VECTOR      <= `RSC_RESET_VECTOR; // [R1]
            PORT_LATCH_VALUE  <= `RSC_PORT_LATCH_RST; // [R3]
            PULLUP_ENABLE     <= 1'b1; // [R3]
            CLK_SRC_INTERNAL  <= 1'b1; // [R5]
            OSC_FREQ_SEL      <= `RSC_OSC_2MHZ; // [R5]
            WATCHDOG_ENABLE   <= 1'b1; // [R5]
            WATCHDOG_INTERVAL <= `RSC_WDT_INTERVAL; // [R5]
        end
    end

endmodule
`default_nettype wire

// ===== verif/rsc_ext_model.sv
`timescale 1ns/1ns
`default_nettype none
module rsc_ext_model
(
    input  wire logic pull_low,
    input  wire logic dut_oe,
    input  wire logic dut_out,
    input  wire logic dip,
    output wire logic pin_n,
    output wire logic supply_low
);
    // Pulled-up pin, low whenever either side pulls it
    assign pin_n      = !(pull_low || (dut_oe && !dut_out));
    assign supply_low = dip;
endmodule
`default_nettype wire

// ===== verif/rsc_reset_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_ctrl_assertions
#(
    parameter POR_CYCLES  = 20,
    parameter LOSS_CYCLES = 8
)
(
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic        SUPPLY_LOW,
    input wire logic        RESET_PIN_N_IN,
    input wire logic        RESET_PIN_N_OE,
    input wire logic        COMPARATOR_PLUS_ABOVE_MINUS,
    input wire logic        CLOCK_LOSS_ENABLE,
    input wire logic        CORE_CLK_TOGGLE,
    input wire logic        RSRC_WR_EN,
    input wire logic [7:0]  RSRC_WR_DATA,
    input wire logic [7:0]  RESET_SOURCE_REG,
    input wire logic        CORE_RST,
    input wire logic        RAM_WRITE_BLOCK,
    input wire logic [15:0] RESET_VECTOR,
    input wire logic [7:0]  PORT_LATCH_VALUE,
    input wire logic        PULLUP_ENABLE,
    input wire logic        CLK_SRC_INTERNAL,
    input wire logic [1:0]  OSC_FREQ_SEL,
    input wire logic        WATCHDOG_ENABLE,
    input wire logic [2:0]  WATCHDOG_INTERVAL
);
    int   pin_hi_q;
    int   pwr_age_q;
    int   oe_cnt_q;
    int   tog_age_q;
    logic arm_q;
    logic tog_q;

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pin_hi_q  <= 0;
            pwr_age_q <= 0;
            oe_cnt_q  <= 0;
            tog_age_q <= 0;
            arm_q     <= 1'b0;
            tog_q     <= 1'b0;
        end
        else
        begin
            pin_hi_q  <= RESET_PIN_N_IN ? pin_hi_q + 1 : 0;
            pwr_age_q <= (SUPPLY_LOW || (RSRC_WR_EN && RSRC_WR_DATA[1])) ? 0 : pwr_age_q + 1;
            oe_cnt_q  <= (RESET_PIN_N_OE && !SUPPLY_LOW) ? oe_cnt_q + 1 : 0;
            tog_q     <= CORE_CLK_TOGGLE;
            tog_age_q <= (CORE_CLK_TOGGLE != tog_q || !CLOCK_LOSS_ENABLE) ? 0 : tog_age_q + 1;
            if (CORE_RST)
                arm_q <= 1'b0;
            else if (RSRC_WR_EN)
                arm_q <= RSRC_WR_DATA[5];
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence s_ext_low;
        !RESET_PIN_N_IN && !RESET_PIN_N_OE;
    endsequence
    sequence s_dip;
        SUPPLY_LOW [*3];
    endsequence

    a_pin_enters_reset: assert property (s_ext_low |-> ##[1:2] CORE_RST) else $error("pin low gave no reset");
    a_pin_hold_len: assert property ($fell(CORE_RST) && RESET_SOURCE_REG[0] |-> pin_hi_q >= 12)
        else $error("pin reset released early");
    a_supply_drive: assert property (s_dip |-> RESET_PIN_N_OE && CORE_RST) else $error("supply low not held");
    a_por_timeout: assert property ($fell(RESET_PIN_N_OE) |-> oe_cnt_q >= POR_CYCLES - 1)
        else $error("pin released before timeout");
    a_pin_not_driven: assert property ($rose(RESET_PIN_N_OE) |-> pwr_age_q <= 4)
        else $error("pin driven for non power reset");
    a_cmp_async: assert property (arm_q && !COMPARATOR_PLUS_ABOVE_MINUS |-> CORE_RST)
        else $error("comparator reset missing");
    a_loss_reset: assert property (tog_age_q > LOSS_CYCLES + 4 |-> CORE_RST) else $error("clock loss missed");
    a_flag_single: assert property ($fell(CORE_RST) |-> $onehot(RESET_SOURCE_REG))
        else $error("flags not single source");
    a_exit_defaults: assert property ($fell(CORE_RST) |-> PORT_LATCH_VALUE == 8'hff && PULLUP_ENABLE
        && RESET_VECTOR == 16'h0000 && CLK_SRC_INTERNAL && OSC_FREQ_SEL == 2'h0
        && WATCHDOG_ENABLE && WATCHDOG_INTERVAL == 3'h7) else $error("exit defaults wrong");
    a_ram_guard: assert property (RAM_WRITE_BLOCK == CORE_RST) else $error("ram guard differs");
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_assertions #(.POR_CYCLES(POR_CYCLES), .LOSS_CYCLES(LOSS_CYCLES)) u_chk
(
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SUPPLY_LOW(SUPPLY_LOW), .RESET_PIN_N_IN(RESET_PIN_N_IN),
    .RESET_PIN_N_OE(RESET_PIN_N_OE), .COMPARATOR_PLUS_ABOVE_MINUS(COMPARATOR_PLUS_ABOVE_MINUS),
    .CLOCK_LOSS_ENABLE(CLOCK_LOSS_ENABLE), .CORE_CLK_TOGGLE(CORE_CLK_TOGGLE), .RSRC_WR_EN(RSRC_WR_EN),
    .RSRC_WR_DATA(RSRC_WR_DATA), .RESET_SOURCE_REG(RESET_SOURCE_REG), .CORE_RST(CORE_RST),
    .RAM_WRITE_BLOCK(RAM_WRITE_BLOCK), .RESET_VECTOR(RESET_VECTOR), .PORT_LATCH_VALUE(PORT_LATCH_VALUE),
    .PULLUP_ENABLE(PULLUP_ENABLE), .CLK_SRC_INTERNAL(CLK_SRC_INTERNAL), .OSC_FREQ_SEL(OSC_FREQ_SEL),
    .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .WATCHDOG_INTERVAL(WATCHDOG_INTERVAL)
);
`default_nettype wire

// ===== verif/rsc_reset_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_ctrl_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        pull = 1'b0;
    logic        dip = 1'b0;
    logic        cnv = 1'b1;
    logic        cmp = 1'b1;
    logic        wdt = 1'b0;
    logic        lce = 1'b0;
    logic        tog = 1'b0;
    logic        tog_run = 1'b1;
    logic        wr_en = 1'b0;
    logic [7:0]  wr_d = 8'h00;
    wire         pin_n, sup, pin_out, oe, core_rst, ram_blk, pu, csrc, wde;
    wire  [7:0]  flags, plv;
    wire  [15:0] vec;
    wire  [1:0]  osc;
    wire  [2:0]  wdi;
    int          n_mismatch = 0;
    int          checked = 0;

    always #50 clk = ~clk;
    always @(posedge clk) if (tog_run) tog <= ~tog;

    rsc_ext_model ext (.pull_low(pull), .dut_oe(oe), .dut_out(pin_out), .dip(dip), .pin_n(pin_n), .supply_low(sup));
    rsc_reset_ctrl #(.POR_CYCLES(20), .POR_CNT_W(20), .LOSS_CYCLES(8), .LOSS_CNT_W(11)) dut
    (
        .CLK_SYS(clk), .SYS_RST(rst), .SUPPLY_LOW(sup), .RESET_PIN_N_IN(pin_n), .RESET_PIN_N_OUT(pin_out),
        .RESET_PIN_N_OE(oe), .CONVERT_START_SIGNAL(cnv), .COMPARATOR_PLUS_ABOVE_MINUS(cmp),
        .WATCHDOG_OVERFLOW(wdt), .CLOCK_LOSS_ENABLE(lce), .CORE_CLK_TOGGLE(tog), .RSRC_WR_EN(wr_en),
        .RSRC_WR_DATA(wr_d), .RESET_SOURCE_REG(flags), .CORE_RST(core_rst), .RAM_WRITE_BLOCK(ram_blk),
        .RESET_VECTOR(vec), .PORT_LATCH_VALUE(plv), .PULLUP_ENABLE(pu), .CLK_SRC_INTERNAL(csrc),
        .OSC_FREQ_SEL(osc), .WATCHDOG_ENABLE(wde), .WATCHDOG_INTERVAL(wdi)
    );

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] d);
        wr_d = d;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
    endtask
    task wait_run(input logic [7:0] exp);
        int i;
        i = 0;
        while (core_rst !== 1'b0 && i < 100)
        begin
            step(1);
            i++;
        end
        chk("core_rst", 16'(core_rst), 16'h0);
        chk("flags", 16'(flags), 16'(exp));
    endtask
    task t_por;
        chk("oe", 16'(oe), 16'h1);
        wait_run(8'h02);
        chk("defaults", 16'({pu, csrc, osc, wde, wdi}), 16'hcf);
        chk("latch", 16'(plv), 16'hff);
        chk("vector", vec, 16'h0000);
    endtask
    task t_pin;
        pull = 1'b1;
        step(3);
        chk("rst", 16'(core_rst), 16'h1);
        chk("oe", 16'(oe), 16'h0);
        pull = 1'b0;
        step(11);
        chk("rst", 16'(core_rst), 16'h1);
        wait_run(8'h01);
    endtask
    task t_sw;
        wr(8'h02);
        step(3);
        chk("oe", 16'(oe), 16'h1);
        chk("rst", 16'(core_rst), 16'h1);
        step(12);
        chk("oe", 16'(oe), 16'h1);
        wait_run(8'h02);
    endtask
    task t_supply;
        dip = 1'b1;
        step(5);
        chk("oe", 16'(oe), 16'h1);
        chk("rst", 16'(core_rst), 16'h1);
        chk("pin_n", 16'(pin_n), 16'h0);
        dip = 1'b0;
        step(15);
        chk("oe", 16'(oe), 16'h1);
        wait_run(8'h02);
    endtask
    task t_loss;
        tog_run = 1'b0;
        step(30);
        chk("rst", 16'(core_rst), 16'h0);
        lce = 1'b1;
        step(20);
        chk("rst", 16'(core_rst), 16'h1);
        chk("oe", 16'(oe), 16'h0);
        tog_run = 1'b1;
        wait_run(8'h04);
    endtask
    task t_cmp;
        wr(8'h00);
        cmp = 1'b0;
        step(3);
        chk("rst", 16'(core_rst), 16'h0);
        cmp = 1'b1;
        wr(8'h20);
        step(1);
        cmp = 1'b0;
        #1;
        chk("rst", 16'(core_rst), 16'h1);
        chk("oe", 16'(oe), 16'h0);
        chk("ram_blk", 16'(ram_blk), 16'h1);
        step(2);
        cmp = 1'b1;
        wait_run(8'h20);
    endtask
    task t_cnv;
        wr(8'h40);
        cnv = 1'b0;
        step(3);
        chk("rst", 16'(core_rst), 16'h1);
        chk("oe", 16'(oe), 16'h0);
        cnv = 1'b1;
        wait_run(8'h40);
    endtask
    task t_wdt;
        wdt = 1'b1;
        step(1);
        wdt = 1'b0;
        step(1);
        chk("rst", 16'(core_rst), 16'h1);
        chk("oe", 16'(oe), 16'h0);
        wait_run(8'h08);
    endtask
    task wrap_up;
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_mismatch++;
        wrap_up;
    end
    initial
    begin
        step(3);
        rst = 1'b0;
        t_por;
        t_pin;
        t_sw;
        t_supply;
        t_loss;
        t_cmp;
        t_cnv;
        t_wdt;
        wrap_up;
    end
endmodule
`default_nettype wire
